/* rtl/flash_erase_consts.vh */
// constants for the host-side nor flash erase sequencer
// assumes a 20 MHz sys_clk and an asynchronous x16 flash bus
`ifndef FLASH_ERASE_CONSTS_VH
`define FLASH_ERASE_CONSTS_VH

`define ADDR_W        26
`define DATA_W        16
`define UNLOCK_A1     26'h0000555
`define UNLOCK_A2     26'h00002aa
`define UNLOCK_D1     16'h00aa
`define UNLOCK_D2     16'h0055
`define CMD_SETUP     16'h0080
`define CMD_DIE       16'h0010
`define CMD_BLOCK     16'h0030
`define CMD_SUSPEND   16'h00b0
`define CMD_RESUME    16'h0030
`define CMD_RESET     16'h00f0
// polling bits: dq7 done-data, dq6 toggle, dq5 fail
`define POLL_DQ7      7
`define POLL_DQ6      6
`define POLL_DQ5      5
// bus cycle timing: 5 clocks low (250 ns), 3 high before ce_n rises
`define T_LOW_CYC     3'h4
`define T_HIGH_CYC    3'h2
`define T_RD_CYC      3'h4
`define OP_DIE        2'h0
`define OP_BLOCK      2'h1
`define OP_SUSPEND    2'h2
`define OP_RESUME     2'h3

`endif

/* rtl/flash_bus_cycle.v */
// one asynchronous write or read cycle on the flash bus
// assumes the caller holds addr and data stable while busy
`timescale 1ns/1ps
`include "flash_erase_consts.vh"

module flash_bus_cycle (
  // clock and reset
  input  wire               sys_clk,
  input  wire               rst,
  // request
  input  wire               start,
  input  wire               is_read,
  input  wire [`ADDR_W-1:0] addr,
  input  wire [`DATA_W-1:0] wdata,
  output reg                busy_r,
  output reg                done_r,
  output reg  [`DATA_W-1:0] rdata_r,
  // flash pins
  input  wire [`DATA_W-1:0] dq_in_sync,
  output reg  [`ADDR_W-1:0] a_r,
  output reg  [`DATA_W-1:0] dq_out_r,
  output reg                dq_oe_r,
  output reg                we_n_r,
  output reg                oe_n_r,
  output reg                ce_n_r
);

  reg [2:0] cnt_r;
  reg       phase_r;
  reg       rd_r;

  always @(posedge sys_clk) begin
    if (rst) begin
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      rdata_r  <= 16'h0000;
      a_r      <= 26'h0000000;
      dq_out_r <= 16'h0000;
      dq_oe_r  <= 1'b0;
      we_n_r   <= 1'b1;
      oe_n_r   <= 1'b1;
      ce_n_r   <= 1'b1;
      cnt_r    <= 3'h0;
      phase_r  <= 1'b0;
      rd_r     <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!busy_r) begin
        if (start) begin
          busy_r   <= 1'b1;
          rd_r     <= is_read;
          a_r      <= addr;
          dq_out_r <= wdata;
          dq_oe_r  <= !is_read;
          ce_n_r   <= 1'b0;
          we_n_r   <= is_read;
          oe_n_r   <= !is_read;
          cnt_r    <= is_read ? `T_RD_CYC : `T_LOW_CYC;
          phase_r  <= 1'b0;
        end
      end else if (cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
      end else if (!phase_r) begin
        // data latched on the rising strobe edge
        if (rd_r)
          rdata_r <= dq_in_sync;
        we_n_r  <= 1'b1;
        oe_n_r  <= 1'b1;
        phase_r <= 1'b1;
        cnt_r   <= `T_HIGH_CYC;
      end else begin
        dq_oe_r <= 1'b0;
        ce_n_r  <= 1'b1;
        busy_r  <= 1'b0;
        done_r  <= 1'b1;
      end
    end
  end

endmodule // flash_bus_cycle

/* rtl/flash_erase_host.v */
// host controller issuing erase, suspend, resume to a nor flash
// assumes the flash is outside the clock domain: read data is
// synchronised; the caller starts one request at a time
`timescale 1ns/1ps
`include "flash_erase_consts.vh"

module flash_erase_host (
  // clock and reset
  input  wire               sys_clk,
  input  wire               rst,
  // request
  input  wire               req,
  input  wire [1:0]         op,
  input  wire               bypass,
  input  wire [`ADDR_W-1:0] target_addr,
  input  wire               accel_req,
  output reg                busy_r,
  output reg                done_r,
  output reg                fail_r,
  output reg                suspended_r,
  // flash pins
  output wire [`ADDR_W-1:0] flash_a,
  input  wire [`DATA_W-1:0] flash_dq_in,
  output wire [`DATA_W-1:0] flash_dq_out,
  output wire               flash_dq_oe,
  output wire               flash_ce_n,
  output wire               flash_we_n,
  output wire               flash_oe_n,
  output reg                high_program_voltage_level_r
);

  localparam S_IDLE = 6'b000001;
  localparam S_WR   = 6'b000010;
  localparam S_POLL = 6'b000100;
  localparam S_CHK  = 6'b001000;
  localparam S_RST  = 6'b010000;
  localparam S_END  = 6'b100000;

  // ----------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------
  reg [`DATA_W-1:0] dq_s1_r;
  reg [`DATA_W-1:0] dq_s2_r;
  always @(posedge sys_clk) begin
    if (rst) begin
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
    end else begin
      dq_s1_r <= flash_dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end

  // ----------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------
  reg [5:0]         state_r;
  reg [2:0]         idx_r;
  reg [2:0]         last_r;
  reg [1:0]         op_r;
  reg [`ADDR_W-1:0] tgt_r;
  reg               prev6_r;
  reg               first_r;
  reg               dq5_seen_r;
  reg               cyc_start_r;
  reg               cyc_read_r;
  reg [`ADDR_W-1:0] cyc_a_r;
  reg [`DATA_W-1:0] cyc_d_r;
  wire              cyc_busy;
  wire              cyc_done;
  wire [`DATA_W-1:0] cyc_rdata;

  // unlock cycle table: index from the start of full sequence
  reg [`ADDR_W-1:0] seq_a;
  reg [`DATA_W-1:0] seq_d;
  always @* begin
    seq_a = `UNLOCK_A1;
    seq_d = `UNLOCK_D1;
    case (idx_r)
      3'h0: begin seq_a = `UNLOCK_A1; seq_d = `UNLOCK_D1; end
      3'h1: begin seq_a = `UNLOCK_A2; seq_d = `UNLOCK_D2; end
      3'h2: begin seq_a = `UNLOCK_A1; seq_d = `CMD_SETUP; end
      3'h3: begin seq_a = `UNLOCK_A1; seq_d = `UNLOCK_D1; end
      3'h4: begin seq_a = `UNLOCK_A2; seq_d = `UNLOCK_D2; end
      default: begin
        seq_a = (op_r == `OP_BLOCK) ? tgt_r : `UNLOCK_A1;
        seq_d = (op_r == `OP_BLOCK) ? `CMD_BLOCK : `CMD_DIE;
      end
    endcase
    // bypass form sends setup at idx 4 then final at 5
    if (op_r == `OP_SUSPEND) begin
      seq_a = tgt_r;
      seq_d = `CMD_SUSPEND;
    end else if (op_r == `OP_RESUME) begin
      seq_a = tgt_r;
      seq_d = `CMD_RESUME;
    end else if (idx_r == 3'h4 && last_r == 3'h5 && first_r) begin
      seq_a = tgt_r;
      seq_d = `CMD_SETUP;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      state_r      <= S_IDLE;
      idx_r        <= 3'h0;
      last_r       <= 3'h5;
      op_r         <= `OP_DIE;
      tgt_r        <= 26'h0000000;
      prev6_r      <= 1'b0;
      first_r      <= 1'b0;
      dq5_seen_r   <= 1'b0;
      cyc_start_r  <= 1'b0;
      cyc_read_r   <= 1'b0;
      cyc_a_r      <= 26'h0000000;
      cyc_d_r      <= 16'h0000;
      busy_r       <= 1'b0;
      done_r       <= 1'b0;
      fail_r       <= 1'b0;
      suspended_r  <= 1'b0;
      high_program_voltage_level_r <= 1'b0;
    end else begin
      done_r      <= 1'b0;
      cyc_start_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (req) begin
            busy_r  <= 1'b1;
            fail_r  <= 1'b0;
            op_r    <= op;
            tgt_r   <= target_addr;
            first_r <= 1'b0;
            dq5_seen_r <= 1'b0;
            high_program_voltage_level_r <= accel_req && (op == `OP_DIE);
            if (op == `OP_SUSPEND || op == `OP_RESUME) begin
              idx_r  <= 3'h5;
              last_r <= 3'h5;
            end else if (bypass || (accel_req && op == `OP_DIE)) begin
              idx_r   <= 3'h4;
              first_r <= 1'b1;
              last_r  <= 3'h5;
            end else begin
              idx_r  <= 3'h0;
              last_r <= 3'h5;
            end
            state_r <= S_WR;
          end
        end
        S_WR: begin
          if (!cyc_busy && !cyc_start_r && !prev6_r) begin
            cyc_start_r <= 1'b1;
            cyc_read_r  <= 1'b0;
            cyc_a_r     <= seq_a;
            cyc_d_r     <= seq_d;
            prev6_r     <= 1'b1;
          end else if (cyc_done) begin
            prev6_r <= 1'b0;
            first_r <= 1'b0;
            if (idx_r == last_r) begin
              case (op_r)
                `OP_SUSPEND: begin
                  suspended_r <= 1'b1;
                  state_r     <= S_END;
                end
                // resume from read mode, then poll
                // this host never enters other modes to leave first
                `OP_RESUME: begin
                  suspended_r <= 1'b0;
                  state_r     <= S_POLL;
                end
                default: state_r <= S_POLL;
              endcase
            end else begin
              idx_r <= idx_r + 3'h1;
            end
          end
        end
        S_POLL: begin
          if (!cyc_busy && !cyc_start_r && !prev6_r) begin
            cyc_start_r <= 1'b1;
            cyc_read_r  <= 1'b1;
            cyc_a_r     <= tgt_r;
            prev6_r     <= 1'b1;
          end else if (cyc_done) begin
            prev6_r <= 1'b0;
            cyc_d_r <= cyc_rdata;
            state_r <= S_CHK;
          end
        end
        // two reads with equal toggle bit means finished
        S_CHK: begin
          if (!cyc_busy && !cyc_start_r && !prev6_r) begin
            cyc_start_r <= 1'b1;
            cyc_read_r  <= 1'b1;
            prev6_r     <= 1'b1;
          end else if (cyc_done) begin
            prev6_r <= 1'b0;
            if (cyc_rdata[`POLL_DQ6] == cyc_d_r[`POLL_DQ6]) begin
              state_r <= S_END;
            end else if (cyc_rdata[`POLL_DQ5] && dq5_seen_r) begin
              fail_r  <= 1'b1;
              state_r <= S_RST;
            end else begin
              // dq5 can rise just as the erase ends: confirm it
              // with one more toggling read before calling a fail
              dq5_seen_r <= cyc_rdata[`POLL_DQ5];
              cyc_d_r    <= cyc_rdata;
            end
          end
        end
        S_RST: begin
          if (!cyc_busy && !cyc_start_r && !prev6_r) begin
            cyc_start_r <= 1'b1;
            cyc_read_r  <= 1'b0;
            cyc_a_r     <= tgt_r;
            cyc_d_r     <= `CMD_RESET;
            prev6_r     <= 1'b1;
          end else if (cyc_done) begin
            prev6_r <= 1'b0;
            state_r <= S_END;
          end
        end
        S_END: begin
          // next erase only after this one
          busy_r  <= 1'b0;
          done_r  <= 1'b1;
          high_program_voltage_level_r <= 1'b0;
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  flash_bus_cycle u_cycle (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .start      (cyc_start_r),
    .is_read    (cyc_read_r),
    .addr       (cyc_a_r),
    .wdata      (cyc_d_r),
    .busy_r     (cyc_busy),
    .done_r     (cyc_done),
    .rdata_r    (cyc_rdata),
    .dq_in_sync (dq_s2_r),
    .a_r        (flash_a),
    .dq_out_r   (flash_dq_out),
    .dq_oe_r    (flash_dq_oe),
    .we_n_r     (flash_we_n),
    .oe_n_r     (flash_oe_n),
    .ce_n_r     (flash_ce_n)
  );

endmodule // flash_erase_host

/* verif/flash_erase_checker.sv */
// pin protocol checker for the erase host
// assumes binding to every flash_erase_host instance
`timescale 1ns/1ps
`include "flash_erase_consts.vh"

module flash_erase_checker (
  input wire               sys_clk,
  input wire               rst,
  input wire               req,
  input wire               busy_r,
  input wire               done_r,
  input wire [`ADDR_W-1:0] flash_a,
  input wire [`DATA_W-1:0] flash_dq_out,
  input wire               flash_dq_oe,
  input wire               flash_ce_n,
  input wire               flash_we_n,
  input wire               flash_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_rst_idle;
    $fell(rst) |-> flash_ce_n && flash_we_n && flash_oe_n && !busy_r;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("bus not idle after reset");
  property p_we_oe;
    !(!flash_we_n && !flash_oe_n);
  endproperty
  a_we_oe: assert property (p_we_oe)
    else $error("write and read strobes both low");
  property p_drive;
    flash_dq_oe |-> flash_oe_n;
  endproperty
  a_drive: assert property (p_drive)
    else $error("host drives data while flash outputs");
  property p_done;
    done_r |=> !done_r;
  endproperty
  a_done: assert property (p_done)
    else $error("done longer than one cycle");
  property p_take;
    req && !busy_r |=> busy_r;
  endproperty
  a_take: assert property (p_take)
    else $error("request not taken");
  property p_we_ce;
    $fell(flash_we_n) |-> !flash_ce_n;
  endproperty
  a_we_ce: assert property (p_we_ce)
    else $error("write strobe without chip select");
  property p_we_len;
    $fell(flash_we_n) |-> !flash_we_n [*4];
  endproperty
  a_we_len: assert property (p_we_len)
    else $error("write pulse too short");
  property p_hold;
    !flash_we_n && !$fell(flash_we_n) |-> $stable(flash_a)
      && $stable(flash_dq_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("address or data moved in write pulse");
endmodule // flash_erase_checker

bind flash_erase_host flash_erase_checker i_chk (
  .sys_clk(sys_clk), .rst(rst), .req(req), .busy_r(busy_r),
  .done_r(done_r), .flash_a(flash_a), .flash_dq_out(flash_dq_out),
  .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
  .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));

/* verif/flash_model.sv */
// behavioural flash die: erase decode and polling status
// assumes one host; events on strobe edges, no clock
`timescale 1ns/1ps

module flash_model (
  // host pins
  input  wire        ce_n,
  input  wire        we_n,
  input  wire        oe_n,
  input  wire [15:0] dq,
  input  wire [25:0] a,
  input  wire        high_program_voltage_level,
  output wire [15:0] dq_o,
  // bench control and write log
  input  wire        fail_mode,
  output reg  [15:0] n_wr,
  output reg  [15:0] n_bad,
  output reg  [15:0] last_cmd
);
  reg        die, blk, susp, err, tog, s80, byp;
  reg [2:0]  left;
  reg [15:0] rd, last_rd;
  initial begin
    {die, blk, susp, err, tog, s80, byp} = 7'h00;
    left = 3'h0; n_wr = 16'h0000; last_cmd = 16'h0000;
    n_bad = 16'h0000;
    last_rd = 16'h0000;
  end
  // erased or readable array reads all ones
  always @* rd = (die | blk | err) ? {9'h000, tog, err, 5'h00} : 16'hffff;
  // released bus shows the inverse of the last value
  assign dq_o = (!ce_n && !oe_n) ? rd : ~last_rd;
  always @(posedge oe_n) if (!ce_n) begin
    last_rd = rd;
    if (die | blk | err) tog = ~tog;
    if (die | blk) begin
      left = left - 3'h1;
      if (left == 3'h0) begin err = fail_mode; die = 0; blk = 0; end
    end
  end
  always @(posedge we_n) if (!ce_n) begin
    n_wr = n_wr + 16'h0001;
    last_cmd = dq;
    // unlock cycles must hit the unlock addresses
    if (dq == 16'h00aa && a != 26'h0000555) n_bad = n_bad + 16'h0001;
    if (dq == 16'h0055 && a != 26'h00002aa) n_bad = n_bad + 16'h0001;
    byp = high_program_voltage_level;
    if (die) ;
    else if (blk) begin
      if (dq == 16'h00b0) begin blk = 0; susp = 1; end
    end
    else if (dq == 16'h00f0) begin err = 0; s80 = 0; end
    else if (s80 && (dq == 16'h0010 || dq == 16'h0030)) begin
      die = (dq == 16'h0010); blk = !die; left = 3'h4; s80 = 0;
    end
    else if (susp && dq == 16'h0030) begin susp = 0; blk = 1; left = 3'h4; end
    else if (dq == 16'h0080) s80 = 1;
    else if (dq != 16'h00aa && dq != 16'h0055) s80 = 0;
  end
endmodule // flash_model

/* verif/tb_top.sv */
// self-checking bench for the erase host with a flash model
// assumes checker is bound; flash model answers on strobes
`timescale 1ns/1ps
`include "flash_erase_consts.vh"

module tb_top;
  reg                sys_clk, rst, req, bypass, accel_req, fail_mode;
  reg  [1:0]         op;
  reg  [`ADDR_W-1:0] target_addr;
  wire               busy_r, done_r, fail_r, suspended_r, hv;
  wire               flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
  wire [`ADDR_W-1:0] flash_a;
  wire [`DATA_W-1:0] flash_dq_in, flash_dq_out, dq_o;
  wire [15:0]        n_wr, last_cmd, n_bad;
  integer            num_errors, n_compared, seed, tot, k;
  reg  [33:0]        exp_q[$];
  reg                hv_seen;

  flash_erase_host i_flash_erase_host (.sys_clk(sys_clk), .rst(rst),
    .req(req), .op(op), .bypass(bypass), .target_addr(target_addr),
    .accel_req(accel_req), .busy_r(busy_r), .done_r(done_r),
    .fail_r(fail_r), .suspended_r(suspended_r), .flash_a(flash_a),
    .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
    .high_program_voltage_level_r(hv));
  flash_model i_flash_model (.ce_n(flash_ce_n), .we_n(flash_we_n),
    .oe_n(flash_oe_n), .dq(flash_dq_out), .a(flash_a), .high_program_voltage_level(hv),
    .dq_o(dq_o), .fail_mode(fail_mode), .n_wr(n_wr), .n_bad(n_bad),
    .last_cmd(last_cmd));
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : dq_o;

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task chk_done(input [33:0] got, input [33:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0t done got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task chk_bit(input got, input exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // each op: expected write count and final code, fail, suspended
  task run_op(input [1:0] o, input b, input a, input f, input [3:0] nw,
              input [15:0] lc, input ef, input es);
    begin
      tot = tot + nw;
      exp_q.push_back({ef, es, tot[15:0], lc});
      @(posedge sys_clk);
      op <= o; bypass <= b; accel_req <= a; fail_mode <= f; req <= 1'b1;
      target_addr <= $random(seed) & 26'h3ff0000;
      @(posedge sys_clk);
      req <= 1'b0;
      k = 0;
      while (done_r !== 1'b1 && k < 20000) begin
        @(negedge sys_clk);
        k = k + 1;
      end
      if (k >= 20000) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0t no done", $time);
      end
    end
  endtask

  // ---------------------------------------------------------------
  // result watcher
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (hv === 1'b1) hv_seen <= 1'b1;
    if (done_r === 1'b1) begin
      if (exp_q.size() == 0) chk_bit(1'b1, 1'b0);
      else chk_done({fail_r, suspended_r, n_wr, last_cmd}, exp_q.pop_front());
    end
  end

  initial begin
    #2000000;
    num_errors = num_errors + 1;
    $display("[ERR] %0t watchdog", $time);
    close_out;
  end

  initial begin
    {rst, req, bypass, accel_req, fail_mode, hv_seen} = 6'h20;
    op = 2'h0; target_addr = 26'h0000000;
    num_errors = 0; n_compared = 0; seed = 97; tot = 0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    run_op(`OP_DIE, 0, 0, 0, 4'h6, 16'h0010, 0, 0);
    run_op(`OP_DIE, 1, 0, 0, 4'h2, 16'h0010, 0, 0);
    run_op(`OP_BLOCK, 0, 0, 0, 4'h6, 16'h0030, 0, 0);
    run_op(`OP_BLOCK, 1, 0, 0, 4'h2, 16'h0030, 0, 0);
    run_op(`OP_SUSPEND, 0, 0, 0, 4'h1, 16'h00b0, 0, 1);
    run_op(`OP_RESUME, 0, 0, 0, 4'h1, 16'h0030, 0, 0);
    run_op(`OP_BLOCK, 0, 0, 1, 4'h7, 16'h00f0, 1, 0);
    run_op(`OP_DIE, 0, 1, 1, 4'h3, 16'h00f0, 1, 0);
    chk_bit(hv_seen, 1'b1);
    chk_bit(n_bad == 16'h0000, 1'b1);
    // abort an erase request by reset during its unlock writes, before the erase command
    @(posedge sys_clk);
    op <= `OP_DIE; fail_mode <= 1'b0; accel_req <= 1'b0; req <= 1'b1;
    @(posedge sys_clk);
    req <= 1'b0;
    repeat (30) @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk_bit(busy_r, 1'b0);
    chk_bit(flash_ce_n, 1'b1);
    chk_bit(exp_q.size() == 0, 1'b1);
    close_out;
  end
endmodule // tb_top
